// ===== hdl/ubl_pkg.sv
`default_nettype none
package ubl_pkg;
    // Clock and link timing
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned DEFAULT_BAUD = 115200;
    localparam int unsigned REF_KHZ      = 3000;   // Divisor reference, 3 MHz
    localparam int unsigned CLK_KHZ      = CLK_HZ / 1000;
    localparam logic [17:0] BIT_CYC_DEFAULT = 18'(CLK_HZ / DEFAULT_BAUD);
    localparam logic [2:0]  STRAP_SETTLE_CYC = 3'h4;

    // Command and answer bytes
    localparam logic [7:0] CMD_LINK_CFG   = 8'h01;
    localparam logic [7:0] CMD_BLOCK_READ = 8'h02;
    localparam logic [7:0] CMD_BLOCK_PROGRAM_SELECT_N = 8'h03;
    localparam logic [7:0] ECHO_A         = 8'hFF;
    localparam logic [7:0] ECHO_B         = 8'hFA;
    localparam logic [7:0] ACK_BYTE       = 8'h02;
    localparam logic [2:0] LINK_CFG_ARGS  = 3'h5;
    localparam logic [2:0] BLOCK_ARGS     = 3'h3;

    // Receive buffer
    localparam int unsigned FIFO_WIDTH     = 8;
    localparam int unsigned FIFO_DEPTH     = 8;
    localparam logic [3:0]  RTS_STOP_LEVEL = 4'h6;
    localparam logic [15:0] PROGRAM_SELECT_N_TIME_RESET = 16'h0000;

    typedef enum logic [3:0] {
        P_IDLE  = 4'b0000,
        P_ARGS  = 4'b0001,
        P_ACK1  = 4'b0010,
        P_WDATA = 4'b0011,
        P_ACK2  = 4'b0100,
        P_RDATA = 4'b0101,
        P_RWAIT = 4'b0110,
        P_RSEND = 4'b0111,
        P_ECHO  = 4'b1000,
        P_APPLY = 4'b1001
    } ubl_state_t;

    // Bit period in core clocks from the 14-bit divisor field; zero means one
    function automatic logic [17:0] ubl_bit_cycles(input logic [23:0] div);
        logic [31:0] d;
        d = {18'h00000, div[13:0]};
        if (d == 32'h0) begin
            d = 32'h1;
        end
        return 18'((d * CLK_KHZ) / REF_KHZ);
    endfunction
endpackage
`default_nettype wire

// ===== hdl/ubl_fifo.sv
`default_nettype none
module ubl_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic                         in_valid,
    output logic                              in_ready,
    input  wire logic [WIDTH-1:0]             in_data,
    output logic                              out_valid,
    input  wire logic                         out_ready,
    output logic [WIDTH-1:0]                  out_data,
    output logic [$clog2(DEPTH+1)-1:0]        level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
    logic [LW-1:0]    cnt_ff, nxt_cnt;
    logic             push, pop;

    // Honest full and empty from the occupancy count
    assign in_ready  = (cnt_ff != LW'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign level     = cnt_ff;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_cnt    = cnt_ff;
        if (push) begin
            nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff    <= nxt_cnt;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/ubl_loader.sv
// Behaviour
// - Link runs at 115200 baud after entry until link configuration changes it.
// - Baud change only through link configuration, after 115200 link works.
// - RTS/CTS flow control paces bytes in both directions.
// - Select sampled at reset release; deasserted means run mode, loader idle.
// - Link config: 0x01, time low/high, three divisor bytes; answer 0x02.
// - Sync bytes 0xFF and 0xFA are echoed unchanged.
// - Program block: 0x03, address, count; ack, data, ack again.
// - Read block: 0x02, address, count; ack, then count data bytes.
`default_nettype none
module ubl_loader
    import ubl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        program_select_n,
    input  wire logic        rxd,
    output logic             txd,
    output logic             rts_n,
    input  wire logic        cts_n,
    output logic             boot_active,
    output logic [15:0]      program_time,
    output logic             flash_wr_en,
    output logic             flash_rd_en,
    input  wire logic        flash_ready,
    output logic [15:0]      flash_addr,
    output logic [7:0]       flash_wdata,
    input  wire logic [7:0]  flash_rdata
);
    import ubl_pkg::*;

    // Pin synchronisers, three stages, value taken when stages two and three agree
    logic [2:0] psel_sy_ff, rxd_sy_ff, cts_sy_ff;
    logic       psel_ff, rxd_ff, cts_ff, nxt_psel, nxt_rxd, nxt_cts;
    always_comb begin
        nxt_psel = (psel_sy_ff[1] == psel_sy_ff[2]) ? psel_sy_ff[2] : psel_ff;
        nxt_rxd  = (rxd_sy_ff[1] == rxd_sy_ff[2]) ? rxd_sy_ff[2] : rxd_ff;
        nxt_cts  = (cts_sy_ff[1] == cts_sy_ff[2]) ? cts_sy_ff[2] : cts_ff;
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            psel_sy_ff <= 3'h7;
            rxd_sy_ff  <= 3'h7;
            cts_sy_ff  <= 3'h7;
            psel_ff    <= 1'b1;
            rxd_ff     <= 1'b1;
            cts_ff     <= 1'b1;
        end else begin
            psel_sy_ff <= {psel_sy_ff[1:0], program_select_n};
            rxd_sy_ff  <= {rxd_sy_ff[1:0], rxd};
            cts_sy_ff  <= {cts_sy_ff[1:0], cts_n};
            psel_ff    <= nxt_psel;
            rxd_ff     <= nxt_rxd;
            cts_ff     <= nxt_cts;
        end
    end

    // Strap capture after reset release, once the synchroniser has settled
    logic [2:0] strap_cnt_ff, nxt_strap_cnt;
    logic       strap_done_ff, nxt_strap_done, boot_ff, nxt_boot;
    always_comb begin
        nxt_strap_cnt  = strap_cnt_ff;
        nxt_strap_done = strap_done_ff;
        nxt_boot       = boot_ff;
        if (!strap_done_ff) begin
            nxt_strap_cnt = strap_cnt_ff + 3'h1;
            if (strap_cnt_ff == STRAP_SETTLE_CYC) begin
                nxt_strap_done = 1'b1;
                nxt_boot       = !psel_ff;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strap_cnt_ff  <= 3'h0;
            strap_done_ff <= 1'b0;
            boot_ff       <= 1'b0;
        end else begin
            strap_cnt_ff  <= nxt_strap_cnt;
            strap_done_ff <= nxt_strap_done;
            boot_ff       <= nxt_boot;
        end
    end
    assign boot_active = boot_ff;

    // Receive buffer between the line receiver and the command parser
    logic       rx_push, fifo_in_ready, fifo_valid, fifo_pop;
    logic [7:0] rx_sh_ff, nxt_rx_sh, fifo_dout;
    logic [3:0] fifo_level;
    ubl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (rx_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_sh_ff),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_dout),
        .level     (fifo_level)
    );
    // Stop the host two bytes early to absorb a byte already on the wire
    assign rts_n = !(boot_ff && (fifo_level < RTS_STOP_LEVEL));

    // Line receiver, mid-bit sampling at the current bit period
    logic [17:0] bit_cyc_ff, nxt_bit_cyc, rx_cnt_ff, nxt_rx_cnt;
    logic [3:0]  rx_bit_ff, nxt_rx_bit;
    logic        rx_busy_ff, nxt_rx_busy, rx_done_ff, nxt_rx_done;
    always_comb begin
        nxt_rx_cnt  = rx_cnt_ff;
        nxt_rx_bit  = rx_bit_ff;
        nxt_rx_busy = rx_busy_ff;
        nxt_rx_sh   = rx_sh_ff;
        nxt_rx_done = 1'b0;
        if (!rx_busy_ff) begin
            if (boot_ff && !rxd_ff) begin
                nxt_rx_busy = 1'b1;
                nxt_rx_bit  = 4'h0;
                nxt_rx_cnt  = bit_cyc_ff >> 1;
            end
        end else if (rx_cnt_ff != 18'h0) begin
            nxt_rx_cnt = rx_cnt_ff - 18'h1;
        end else begin
            nxt_rx_cnt = bit_cyc_ff - 18'h1;
            nxt_rx_bit = rx_bit_ff + 4'h1;
            if (rx_bit_ff == 4'h0 && rxd_ff) begin
                nxt_rx_busy = 1'b0;                           // False start
            end else if (rx_bit_ff == 4'h9) begin
                nxt_rx_busy = 1'b0;
                nxt_rx_done = rxd_ff;                         // Good stop bit only
            end else if (rx_bit_ff != 4'h0) begin
                nxt_rx_sh = {rxd_ff, rx_sh_ff[7:1]};
            end
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_cnt_ff  <= 18'h0;
            rx_bit_ff  <= 4'h0;
            rx_busy_ff <= 1'b0;
            rx_sh_ff   <= 8'h00;
            rx_done_ff <= 1'b0;
        end else begin
            rx_cnt_ff  <= nxt_rx_cnt;
            rx_bit_ff  <= nxt_rx_bit;
            rx_busy_ff <= nxt_rx_busy;
            rx_sh_ff   <= nxt_rx_sh;
            rx_done_ff <= nxt_rx_done;
        end
    end
    assign rx_push = rx_done_ff;

    // Line transmitter; a byte starts only while the host grants CTS
    logic        tx_req, tx_take, tx_busy_ff, nxt_tx_busy, txd_ff, nxt_txd;
    logic [17:0] tx_cnt_ff, nxt_tx_cnt;
    logic [3:0]  tx_bit_ff, nxt_tx_bit;
    logic [8:0]  tx_sh_ff, nxt_tx_sh;
    logic [7:0]  tx_byte_ff, nxt_tx_byte;
    assign tx_take = tx_req && !tx_busy_ff && !cts_ff;
    always_comb begin
        nxt_tx_busy = tx_busy_ff;
        nxt_tx_cnt  = tx_cnt_ff;
        nxt_tx_bit  = tx_bit_ff;
        nxt_tx_sh   = tx_sh_ff;
        nxt_txd     = txd_ff;
        if (tx_take) begin
            nxt_tx_busy = 1'b1;
            nxt_tx_cnt  = bit_cyc_ff - 18'h1;
            nxt_tx_bit  = 4'h0;
            nxt_tx_sh   = {1'b1, tx_byte_ff};
            nxt_txd     = 1'b0;
        end else if (tx_busy_ff) begin
            if (tx_cnt_ff != 18'h0) begin
                nxt_tx_cnt = tx_cnt_ff - 18'h1;
            end else if (tx_bit_ff == 4'h9) begin
                nxt_tx_busy = 1'b0;
            end else begin
                nxt_tx_cnt = bit_cyc_ff - 18'h1;
                nxt_tx_bit = tx_bit_ff + 4'h1;
                nxt_txd    = tx_sh_ff[0];
                nxt_tx_sh  = {1'b1, tx_sh_ff[8:1]};
            end
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_busy_ff <= 1'b0;
            tx_cnt_ff  <= 18'h0;
            tx_bit_ff  <= 4'h0;
            tx_sh_ff   <= 9'h1FF;
            txd_ff     <= 1'b1;
        end else begin
            tx_busy_ff <= nxt_tx_busy;
            tx_cnt_ff  <= nxt_tx_cnt;
            tx_bit_ff  <= nxt_tx_bit;
            tx_sh_ff   <= nxt_tx_sh;
            txd_ff     <= nxt_txd;
        end
    end
    assign txd = txd_ff;

    // Command parser
    ubl_state_t  st_ff, nxt_st;
    logic [7:0]  cmd_ff, nxt_cmd;
    logic [7:0]  arg_ff [5];
    logic [7:0]  nxt_arg [5];
    logic [2:0]  arg_cnt_ff, nxt_arg_cnt, arg_need;
    logic [7:0]  remain_ff, nxt_remain;
    logic [15:0] addr_ff, nxt_addr, ptime_ff, nxt_ptime;
    assign arg_need    = (cmd_ff == CMD_LINK_CFG) ? LINK_CFG_ARGS : BLOCK_ARGS;
    assign tx_req      = (st_ff == P_ACK1) || (st_ff == P_ACK2) ||
                         (st_ff == P_RSEND) || (st_ff == P_ECHO);
    assign flash_wr_en = (st_ff == P_WDATA) && fifo_valid;
    assign flash_rd_en = (st_ff == P_RDATA);
    assign fifo_pop    = (st_ff == P_IDLE || st_ff == P_ARGS) ? fifo_valid
                       : (flash_wr_en && flash_ready);
    assign flash_addr   = addr_ff;
    assign flash_wdata  = fifo_dout;
    assign program_time = ptime_ff;
    always_comb begin
        nxt_st      = st_ff;
        nxt_cmd     = cmd_ff;
        nxt_arg     = arg_ff;
        nxt_arg_cnt = arg_cnt_ff;
        nxt_remain  = remain_ff;
        nxt_addr    = addr_ff;
        nxt_ptime   = ptime_ff;
        nxt_tx_byte = tx_byte_ff;
        nxt_bit_cyc = bit_cyc_ff;
        case (st_ff)
            P_IDLE: begin
                if (fifo_valid) begin
                    if (fifo_dout == ECHO_A || fifo_dout == ECHO_B) begin
                        nxt_tx_byte = fifo_dout;
                        nxt_st      = P_ECHO;
                    end else if (fifo_dout == CMD_LINK_CFG || fifo_dout == CMD_BLOCK_READ ||
                                 fifo_dout == CMD_BLOCK_PROGRAM_SELECT_N) begin
                        nxt_cmd     = fifo_dout;
                        nxt_arg_cnt = 3'h0;
                        nxt_st      = P_ARGS;
                    end
                end
            end
            P_ARGS: begin
                if (fifo_valid) begin
                    nxt_arg[arg_cnt_ff] = fifo_dout;
                    nxt_arg_cnt         = arg_cnt_ff + 3'h1;
                    if (arg_cnt_ff == arg_need - 3'h1) begin
                        nxt_tx_byte = ACK_BYTE;
                        nxt_st      = P_ACK1;
                    end
                end
            end
            P_ACK1: begin
                if (tx_take) begin
                    nxt_addr   = {arg_ff[1], arg_ff[0]};
                    nxt_remain = arg_ff[2];
                    if (cmd_ff == CMD_LINK_CFG) begin
                        nxt_st = P_APPLY;
                    end else if (cmd_ff == CMD_BLOCK_PROGRAM_SELECT_N) begin
                        nxt_st = (arg_ff[2] == 8'h00) ? P_ACK2 : P_WDATA;
                    end else begin
                        nxt_st = (arg_ff[2] == 8'h00) ? P_IDLE : P_RDATA;
                    end
                end
            end
            P_WDATA: begin
                if (fifo_pop) begin
                    nxt_addr   = addr_ff + 16'h1;
                    nxt_remain = remain_ff - 8'h1;
                    if (remain_ff == 8'h1) begin
                        nxt_st = P_ACK2;
                    end
                end
            end
            P_ACK2: begin
                if (tx_take) begin
                    nxt_st = P_IDLE;
                end
            end
            P_RDATA: begin
                if (flash_ready) begin
                    nxt_st = P_RWAIT;
                end
            end
            P_RWAIT: begin
                nxt_tx_byte = flash_rdata;
                nxt_st      = P_RSEND;
            end
            P_RSEND: begin
                if (tx_take) begin
                    nxt_addr   = addr_ff + 16'h1;
                    nxt_remain = remain_ff - 8'h1;
                    nxt_st     = (remain_ff == 8'h1) ? P_IDLE : P_RDATA;
                end
            end
            P_ECHO: begin
                if (tx_take) begin
                    nxt_st = P_IDLE;
                end
            end
            P_APPLY: begin
                // New rate only once the acknowledge has left at the old rate
                if (!tx_busy_ff && !rx_busy_ff) begin
                    nxt_bit_cyc = ubl_bit_cycles({arg_ff[4], arg_ff[3], arg_ff[2]});
                    nxt_ptime   = {arg_ff[1], arg_ff[0]};
                    nxt_st      = P_IDLE;
                end
            end
            default: begin
                nxt_st = P_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff      <= P_IDLE;
            cmd_ff     <= 8'h00;
            arg_ff     <= '{default: 8'h00};
            arg_cnt_ff <= 3'h0;
            remain_ff  <= 8'h00;
            addr_ff    <= 16'h0000;
            ptime_ff   <= PROGRAM_SELECT_N_TIME_RESET;
            tx_byte_ff <= 8'h00;
            bit_cyc_ff <= BIT_CYC_DEFAULT;
        end else begin
            st_ff      <= nxt_st;
            cmd_ff     <= nxt_cmd;
            arg_ff     <= nxt_arg;
            arg_cnt_ff <= nxt_arg_cnt;
            remain_ff  <= nxt_remain;
            addr_ff    <= nxt_addr;
            ptime_ff   <= nxt_ptime;
            tx_byte_ff <= nxt_tx_byte;
            bit_cyc_ff <= nxt_bit_cyc;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_read_issue;
        (st_ff == P_RDATA) && flash_ready;
    endsequence
    sequence s_read_return;
        (st_ff == P_RWAIT) ##1 ((st_ff == P_RSEND) && (tx_byte_ff == $past(flash_rdata)));
    endsequence

    a_run_mode_rts: assert property (!boot_ff |-> rts_n)
        else $error("rts granted while loader inactive");
    a_strap_sample: assert property ($rose(strap_done_ff) |-> (boot_ff == !$past(psel_ff)))
        else $error("boot mode does not follow sampled select");
    a_baud_default: assert property (!strap_done_ff |-> (bit_cyc_ff == BIT_CYC_DEFAULT))
        else $error("bit period not at default after reset");
    a_baud_hold: assert property ((st_ff != P_APPLY) |=> $stable(bit_cyc_ff))
        else $error("bit period changed outside link configuration");
    a_tx_cts_gate: assert property ($rose(tx_busy_ff) |-> !$past(cts_ff))
        else $error("byte started without cts");
    a_echo_byte: assert property ((st_ff == P_IDLE && fifo_valid &&
        (fifo_dout == ECHO_A || fifo_dout == ECHO_B)) |=>
        (st_ff == P_ECHO && tx_byte_ff == $past(fifo_dout)))
        else $error("sync byte not echoed unchanged");
    a_cfg_ack: assert property ((st_ff == P_ARGS && fifo_valid && cmd_ff == CMD_LINK_CFG &&
        arg_cnt_ff == 3'h4) |=> (tx_req && tx_byte_ff == ACK_BYTE))
        else $error("link configuration not acknowledged");
    a_program_select_n_ack2: assert property ((st_ff == P_WDATA && fifo_pop && remain_ff == 8'h1) |=>
        (st_ff == P_ACK2 && tx_byte_ff == ACK_BYTE))
        else $error("second acknowledge missing after block");
    a_read_data: assert property (s_read_issue |=> s_read_return)
        else $error("read data not returned in order");
    a_rts_full: assert property ((fifo_level >= RTS_STOP_LEVEL) |-> rts_n)
        else $error("rts granted with buffer nearly full");
endmodule
`default_nettype wire

// ===== test/ubl_host.sv
`default_nettype none
module ubl_host (
    input  wire logic core_clk,
    output logic      rxd,
    input  wire logic txd,
    input  wire logic rts_n,
    output logic      cts_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int         bit_cyc   = 217;  // Opens at the default rate
    int         stalls    = 0;
    logic       cts_block = 1'b0;
    logic [7:0] rx_q [$];

    // Clear-to-send pacing of device replies
    assign cts_n = cts_block;
    initial rxd = 1'b1;

    // One 8N1 byte, LSB first, paced by ready-to-send
    task automatic send(input logic [7:0] b, input bit paced);
        logic [9:0] fr;
        int         n;
        fr = {1'b1, b, 1'b0};
        n = 0;
        while (paced && rts_n !== 1'b0 && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 20000) stalls++;
        @(negedge core_clk);
        for (int i = 0; i < 10; i++) begin
            rxd = fr[i];
            repeat (bit_cyc) @(negedge core_clk);
        end
    endtask

    // Receiver: mid-bit sampling, stop bit must be high
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge core_clk);
            if (txd === 1'b0) begin
                repeat (bit_cyc / 2) @(negedge core_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (bit_cyc) @(negedge core_clk);
                    b[i] = txd;
                end
                repeat (bit_cyc) @(negedge core_clk);
                if (txd !== 1'b1) stalls++;
                rx_q.push_back(b);
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/uart_bootloader_entry_and_link_tb.sv
`default_nettype none
module uart_bootloader_entry_and_link_tb;
    import ubl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        program_select_n = 1'b1;
    logic        rxd, txd, rts_n, cts_n, boot_active, flash_wr_en, flash_rd_en;
    logic        flash_ready = 1'b0;
    logic        rd_pend = 1'b0;
    logic [15:0] program_time, flash_addr, rd_addr, base;
    logic [7:0]  flash_wdata, got;
    logic [7:0]  flash_rdata = 8'h00;
    logic [7:0]  mem [0:255];
    logic [7:0]  wdat [4];
    logic [15:0] wr_addr [$];
    logic [16:0] seed = 17'h13615;
    int          failures = 0;
    int          check_count = 0;

    always #20 core_clk = ~core_clk;

    ubl_loader u_dut (.core_clk, .rstn, .program_select_n, .rxd, .txd, .rts_n, .cts_n,
        .boot_active, .program_time, .flash_wr_en, .flash_rd_en, .flash_ready,
        .flash_addr, .flash_wdata, .flash_rdata);
    ubl_host u_host (.core_clk, .rxd, .txd, .rts_n, .cts_n);

    // Random source, fixed start
    function automatic logic [7:0] rnd();
        seed = {seed[15:0], seed[16] ^ seed[13]};
        return seed[7:0];
    endfunction

    // Bit period in core clocks for a divisor of the 3 MHz reference
    function automatic int bit_period(input int div);
        return div * 25000 / 3000;
    endfunction

    // Flash: random ready, read data one cycle after the accepted read
    always @(posedge core_clk) begin
        if (flash_wr_en && flash_ready) begin
            mem[flash_addr[7:0]] <= flash_wdata;
            wr_addr.push_back(flash_addr);
        end
        rd_pend <= flash_rd_en && flash_ready;
        if (flash_rd_en && flash_ready) rd_addr <= flash_addr;
    end
    always @(negedge core_clk) begin
        flash_ready <= (rnd() > 8'h50);
        flash_rdata <= rd_pend ? mem[rd_addr[7:0]] : ~flash_rdata;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        failures += u_host.stalls;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic send_q(input logic [7:0] q[$]);
        foreach (q[i]) u_host.send(q[i], 1'b1);
    endtask

    // Bounded wait for the next reply byte
    task automatic expect_byte(input string what, input logic [7:0] exp);
        int n;
        n = 0;
        while (u_host.rx_q.size() == 0 && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        got = (n < 30000) ? u_host.rx_q.pop_front() : 8'hXX;
        check(what, {8'h00, exp}, {8'h00, got});
        if (n == 30000) final_report();
    endtask

    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        final_report();
    end

    initial begin
        repeat (2) @(negedge core_clk);
        check("txd in reset", 16'h0001, {15'h0, txd});
        check("rts_n in reset", 16'h0001, {15'h0, rts_n});
        rstn = 1'b1;
        repeat (12) @(negedge core_clk);
        check("boot_active run", 16'h0000, {15'h0, boot_active});
        check("rts_n run", 16'h0001, {15'h0, rts_n});
        u_host.send(ECHO_A, 1'b0);
        repeat (600) @(negedge core_clk);
        check("run mode replies", 16'h0000, 16'(u_host.rx_q.size()));
        $display("test run_mode done");
        // Entry: select low first, then a reset pulse
        program_select_n = 1'b0;
        repeat (5) @(negedge core_clk);
        rstn = 1'b0;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (12) @(negedge core_clk);
        check("boot_active entry", 16'h0001, {15'h0, boot_active});
        check("program_time reset", 16'h0000, program_time);
        send_q({ECHO_A});
        expect_byte("echo ff", ECHO_A);
        send_q({ECHO_B});
        expect_byte("echo fa", ECHO_B);
        $display("test entry_sync done");
        // Rate change to divisor 3, program time 0x1770
        send_q({CMD_LINK_CFG, 8'h70, 8'h17, 8'h03, 8'h00, 8'h00});
        expect_byte("link ack", ACK_BYTE);
        // New rate and time land only after the acknowledge stop bit has left
        repeat (150) @(negedge core_clk);
        check("program_time", 16'h1770, program_time);
        u_host.bit_cyc = bit_period(3);
        send_q({ECHO_B});
        expect_byte("echo new rate", ECHO_B);
        // Reply held back while clear-to-send is high
        // Six bytes queue behind the held echo and fill the buffer to the stop level
        u_host.cts_block = 1'b1;
        send_q({ECHO_A, ECHO_B, ECHO_B, ECHO_B, ECHO_B, ECHO_B, ECHO_B});
        repeat (400) @(negedge core_clk);
        check("held reply", 16'h0000, 16'(u_host.rx_q.size()));
        check("txd idle held", 16'h0001, {15'h0, txd});
        check("rts_n buffer full", 16'h0001, {15'h0, rts_n});
        u_host.cts_block = 1'b0;
        expect_byte("released reply", ECHO_A);
        repeat (6) expect_byte("released queue", ECHO_B);
        $display("test link_cfg done");
        // Program a random block of four bytes
        base = {rnd(), rnd()};
        send_q({CMD_BLOCK_PROGRAM_SELECT_N, base[7:0], base[15:8], 8'h04});
        expect_byte("program_select_n ack1", ACK_BYTE);
        foreach (wdat[i]) wdat[i] = rnd();
        send_q({wdat[0], wdat[1], wdat[2], wdat[3]});
        expect_byte("program_select_n ack2", ACK_BYTE);
        check("write count", 16'h0004, 16'(wr_addr.size()));
        foreach (wr_addr[i]) check("write addr", base + 16'(i), wr_addr[i]);
        // Read the block back
        send_q({CMD_BLOCK_READ, base[7:0], base[15:8], 8'h04});
        expect_byte("read ack", ACK_BYTE);
        foreach (wdat[i]) expect_byte("read data", wdat[i]);
        // Zero count: both acknowledges back to back
        send_q({CMD_BLOCK_PROGRAM_SELECT_N, rnd(), rnd(), 8'h00});
        expect_byte("zero ack1", ACK_BYTE);
        expect_byte("zero ack2", ACK_BYTE);
        $display("test block_rw done");
        // Back to run mode: select high, then a reset pulse
        program_select_n = 1'b1;
        repeat (5) @(negedge core_clk);
        rstn = 1'b0;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (12) @(negedge core_clk);
        check("boot_active exit", 16'h0000, {15'h0, boot_active});
        check("rts_n exit", 16'h0001, {15'h0, rts_n});
        // Fixed strap: select already low while the device is held off
        rstn = 1'b0;
        program_select_n = 1'b0;
        repeat (5) @(negedge core_clk);
        rstn = 1'b1;
        repeat (12) @(negedge core_clk);
        check("boot_active strap", 16'h0001, {15'h0, boot_active});
        u_host.bit_cyc = CLK_HZ / DEFAULT_BAUD;
        send_q({ECHO_A});
        expect_byte("echo default rate", ECHO_A);
        $display("test mode_exit done");
        final_report();
    end
endmodule
`default_nettype wire
